// file: hw/lpric_pkg.sv
// lpric_pkg: register map, field positions and reset values of the result and
// interrupt control block.
// assumes: byte-wide registers reached over the two-wire serial port.
package lpric_pkg;

    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ALS_PARAM = 8'h84;
    localparam logic [7:0] ADDR_ALS_HI = 8'h85;
    localparam logic [7:0] ADDR_ALS_LO = 8'h86;
    localparam logic [7:0] ADDR_PROX_HI = 8'h87;
    localparam logic [7:0] ADDR_PROX_LO = 8'h88;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h89;
    localparam logic [7:0] ADDR_THR_LOW_HI = 8'h8a;
    localparam logic [7:0] ADDR_THR_LOW_LO = 8'h8b;
    localparam logic [7:0] ADDR_THR_HIGH_HI = 8'h8c;
    localparam logic [7:0] ADDR_THR_HIGH_LO = 8'h8d;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h8e;

    // ------------------------------------------------------------
    // interrupt control fields
    // ------------------------------------------------------------
    localparam int CTRL_COUNT_LSB = 5;
    localparam int CTRL_PROX_EN_BIT = 3;
    localparam int CTRL_ALS_EN_BIT = 2;
    localparam int CTRL_THR_EN_BIT = 1;
    localparam int CTRL_THR_SEL_BIT = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'hef;

    // ------------------------------------------------------------
    // interrupt status fields
    // ------------------------------------------------------------
    localparam int STAT_PROX_BIT = 3;
    localparam int STAT_ALS_BIT = 2;
    localparam int STAT_LOW_BIT = 1;
    localparam int STAT_HIGH_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] INT_CTRL_RESET = 8'h00;
    localparam logic [7:0] ALS_PARAM_RESET = 8'h08;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] THRESHOLD_RESET = 16'h0000;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    // ------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum logic [1:0] {
        LPRIC_PH_ADDR,
        LPRIC_PH_POINTER,
        LPRIC_PH_DATA
    } lpric_phase_type;

    typedef enum logic [2:0] {
        LPRIC_ST_IDLE,
        LPRIC_ST_RX,
        LPRIC_ST_RX_ACK,
        LPRIC_ST_TX,
        LPRIC_ST_TX_ACK,
        LPRIC_ST_TX_LOAD
    } lpric_state_type;

endpackage

// file: hw/lpric_pin_sync.sv
// lpric_pin_sync: three-stage synchroniser with agreement filter for one pin.
// assumes: pin is asynchronous to the core clock.
`timescale 1ns/100ps
module lpric_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pin and filtered level
    input wire logic pin_in,
    output logic level_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // ------------------------------------------------------------
    // sync chain, level changes when stages two and three agree
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level_out <= RESET_LEVEL;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end

endmodule // lpric_pin_sync

// file: hw/lpric_ctrl.sv
// lpric_ctrl: light and proximity result registers, thresholds and interrupt
// control, reached over a two-wire serial slave port.
// assumes: measurement engines on the core clock give one-cycle valid pulses;
// the serial bus has an external pull-up and no clock stretching.
`timescale 1ns/100ps

// How it works
// [RQ1] ambient result high byte at 0x85, low byte at 0x86
// [RQ2] ambient result bytes read-only; writes leave the result unchanged
// [RQ3] proximity result high byte at 0x87, low byte at 0x88
// [RQ4] proximity result bytes read-only, bits 15:8 high and 7:0 low
// [RQ5] control 0x89: count 7:5, prox en, ambient en, threshold en, source
// [RQ6] threshold interrupt after 2^N consecutive out-of-range measurements
// [RQ7] only the selected measurement is compared with the thresholds
// [RQ8] ambient parameter write waits until timed mode is cycled
// [RQ9] source select 0 picks proximity, 1 picks ambient light
// [RQ10] low threshold 0x8A/0x8B, high threshold 0x8C/0x8D, upper byte first
// [RQ11] status 0x8E: prox ready, ambient ready, low, high crossing
// [RQ12] status bits sticky until written 1; interrupt low while any set
module lpric_ctrl #(
    parameter logic [6:0] DEVICE_ADDR = 7'h2a
) (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    // two-wire serial port
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N_OUT,
    // measurement engines
    input wire logic ALS_VALID_IN,
    input wire logic [15:0] ALS_DATA_IN,
    input wire logic PROX_VALID_IN,
    input wire logic [15:0] PROX_DATA_IN,
    input wire logic ALS_TIMED_ON_IN,
    // outputs
    output logic [7:0] ALS_PARAM_OUT,
    output logic INT_N_OUT
);

    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    lpric_pkg::lpric_state_type state;
    lpric_pkg::lpric_phase_type phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd_mode;
    logic [15:0] als_result;
    logic [15:0] prox_result;
    logic [7:0] int_ctrl;
    logic [15:0] thr_low;
    logic [15:0] thr_high;
    logic [3:0] status;
    logic [7:0] als_param_pending;
    logic als_timed_d;
    logic [7:0] high_cnt;
    logic [7:0] low_cnt;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    lpric_pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
        .clk(CORE_CLK_IN),
        .rst_n(NRST_IN),
        .pin_in(SCL_IN),
        .level_out(scl)
    );

    lpric_pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
        .clk(CORE_CLK_IN),
        .rst_n(NRST_IN),
        .pin_in(SDA_IN),
        .level_out(sda)
    );

    // ------------------------------------------------------------
    // bus events
    // ------------------------------------------------------------
    wire scl_rise = scl & ~scl_d;
    wire scl_fall = ~scl & scl_d;
    wire bus_start = scl & scl_d & sda_d & ~sda;
    wire bus_stop = scl & scl_d & ~sda_d & sda;
    wire byte_done = scl_fall && (bit_cnt == lpric_pkg::BITS_PER_BYTE);
    wire addr_match = (shift[7:1] == DEVICE_ADDR);
    wire wr_en = (state == lpric_pkg::LPRIC_ST_RX) && byte_done
        && (phase == lpric_pkg::LPRIC_PH_DATA);
    wire [7:0] next_ptr = ptr + 8'h01;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    wire wr_ctrl = wr_en && (ptr == lpric_pkg::ADDR_INT_CTRL);
    wire wr_param = wr_en && (ptr == lpric_pkg::ADDR_ALS_PARAM);
    wire wr_low_hi = wr_en && (ptr == lpric_pkg::ADDR_THR_LOW_HI);
    wire wr_low_lo = wr_en && (ptr == lpric_pkg::ADDR_THR_LOW_LO);
    wire wr_high_hi = wr_en && (ptr == lpric_pkg::ADDR_THR_HIGH_HI);
    wire wr_high_lo = wr_en && (ptr == lpric_pkg::ADDR_THR_HIGH_LO);
    wire wr_status = wr_en && (ptr == lpric_pkg::ADDR_INT_STATUS);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // [RQ1] [RQ3] result byte placement
    wire [7:0] rd_data =
        (ptr == lpric_pkg::ADDR_ALS_HI) ? als_result[15:8] :
        (ptr == lpric_pkg::ADDR_ALS_LO) ? als_result[7:0] :
        (ptr == lpric_pkg::ADDR_PROX_HI) ? prox_result[15:8] :
        (ptr == lpric_pkg::ADDR_PROX_LO) ? prox_result[7:0] :
        (ptr == lpric_pkg::ADDR_INT_CTRL) ? int_ctrl :
        (ptr == lpric_pkg::ADDR_ALS_PARAM) ? als_param_pending :
        (ptr == lpric_pkg::ADDR_THR_LOW_HI) ? thr_low[15:8] :
        (ptr == lpric_pkg::ADDR_THR_LOW_LO) ? thr_low[7:0] :
        (ptr == lpric_pkg::ADDR_THR_HIGH_HI) ? thr_high[15:8] :
        (ptr == lpric_pkg::ADDR_THR_HIGH_LO) ? thr_high[7:0] :
        (ptr == lpric_pkg::ADDR_INT_STATUS) ? {4'h0, status} : 8'h00;

    // ------------------------------------------------------------
    // serial slave engine
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state <= lpric_pkg::LPRIC_ST_IDLE;
            phase <= lpric_pkg::LPRIC_PH_ADDR;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            ptr <= lpric_pkg::POINTER_RESET;
            rd_mode <= 1'b0;
            SDA_OUT <= 1'b0;
            SDA_OE_N_OUT <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            SDA_OUT <= 1'b0;
            if (bus_start) begin
                state <= lpric_pkg::LPRIC_ST_RX;
                phase <= lpric_pkg::LPRIC_PH_ADDR;
                bit_cnt <= 4'h0;
                SDA_OE_N_OUT <= 1'b1;
            end else if (bus_stop) begin
                state <= lpric_pkg::LPRIC_ST_IDLE;
                SDA_OE_N_OUT <= 1'b1;
            end else begin
                unique case (state)
                    lpric_pkg::LPRIC_ST_IDLE: begin
                        SDA_OE_N_OUT <= 1'b1;
                    end
                    lpric_pkg::LPRIC_ST_RX: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (byte_done) begin
                            bit_cnt <= 4'h0;
                            if (phase != lpric_pkg::LPRIC_PH_ADDR || addr_match) begin
                                SDA_OE_N_OUT <= 1'b0;
                                state <= lpric_pkg::LPRIC_ST_RX_ACK;
                            end else begin
                                state <= lpric_pkg::LPRIC_ST_IDLE;
                            end
                            if (phase == lpric_pkg::LPRIC_PH_ADDR) begin
                                rd_mode <= shift[0];
                            end
                            if (phase == lpric_pkg::LPRIC_PH_POINTER) begin
                                ptr <= shift;
                            end
                            if (phase == lpric_pkg::LPRIC_PH_DATA) begin
                                ptr <= next_ptr;
                            end
                        end
                    end
                    lpric_pkg::LPRIC_ST_RX_ACK: begin
                        if (scl_fall) begin
                            if (phase == lpric_pkg::LPRIC_PH_ADDR && rd_mode) begin
                                state <= lpric_pkg::LPRIC_ST_TX;
                                shift <= rd_data;
                                SDA_OE_N_OUT <= rd_data[7];
                                ptr <= next_ptr;
                                bit_cnt <= 4'h1;
                            end else begin
                                state <= lpric_pkg::LPRIC_ST_RX;
                                SDA_OE_N_OUT <= 1'b1;
                                if (phase == lpric_pkg::LPRIC_PH_ADDR) begin
                                    phase <= lpric_pkg::LPRIC_PH_POINTER;
                                end else begin
                                    phase <= lpric_pkg::LPRIC_PH_DATA;
                                end
                            end
                        end
                    end
                    lpric_pkg::LPRIC_ST_TX: begin
                        if (byte_done) begin
                            SDA_OE_N_OUT <= 1'b1;
                            state <= lpric_pkg::LPRIC_ST_TX_ACK;
                        end else if (scl_fall) begin
                            shift <= {shift[6:0], 1'b0};
                            SDA_OE_N_OUT <= shift[6];
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    lpric_pkg::LPRIC_ST_TX_ACK: begin
                        if (scl_rise) begin
                            state <= sda ? lpric_pkg::LPRIC_ST_IDLE
                                : lpric_pkg::LPRIC_ST_TX_LOAD;
                        end
                    end
                    lpric_pkg::LPRIC_ST_TX_LOAD: begin
                        if (scl_fall) begin
                            state <= lpric_pkg::LPRIC_ST_TX;
                            shift <= rd_data;
                            SDA_OE_N_OUT <= rd_data[7];
                            ptr <= next_ptr;
                            bit_cnt <= 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // threshold evaluation
    // ------------------------------------------------------------
    // [RQ7] [RQ9] compare only the selected source
    wire thr_sel = int_ctrl[lpric_pkg::CTRL_THR_SEL_BIT];
    wire sel_valid = thr_sel ? ALS_VALID_IN : PROX_VALID_IN;
    wire [15:0] sel_data = thr_sel ? ALS_DATA_IN : PROX_DATA_IN;
    wire above = sel_data > thr_high;
    wire below = sel_data < thr_low;
    // [RQ6] run length of 2^N measurements
    wire [7:0] cnt_target = 8'h01 << int_ctrl[lpric_pkg::CTRL_COUNT_LSB +: 3];
    wire [7:0] next_high_cnt = !above ? 8'h00
        : (high_cnt == 8'hff) ? high_cnt : high_cnt + 8'h01;
    wire [7:0] next_low_cnt = !below ? 8'h00
        : (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
    wire thr_en = int_ctrl[lpric_pkg::CTRL_THR_EN_BIT];
    wire high_fire = sel_valid && thr_en && above && (next_high_cnt == cnt_target);
    wire low_fire = sel_valid && thr_en && below && (next_low_cnt == cnt_target);
    wire prox_fire = PROX_VALID_IN && int_ctrl[lpric_pkg::CTRL_PROX_EN_BIT];
    wire als_fire = ALS_VALID_IN && int_ctrl[lpric_pkg::CTRL_ALS_EN_BIT];
    wire [3:0] status_set = {prox_fire, als_fire, low_fire, high_fire};
    wire [3:0] status_clr = wr_status ? shift[3:0] : 4'h0;
    // [RQ12] set wins over a write-one clear
    wire [3:0] next_status = (status & ~status_clr) | status_set;
    wire als_timed_rise = ALS_TIMED_ON_IN & ~als_timed_d;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            als_result <= lpric_pkg::RESULT_RESET;
            prox_result <= lpric_pkg::RESULT_RESET;
            int_ctrl <= lpric_pkg::INT_CTRL_RESET;
            thr_low <= lpric_pkg::THRESHOLD_RESET;
            thr_high <= lpric_pkg::THRESHOLD_RESET;
            status <= lpric_pkg::STATUS_RESET;
            als_param_pending <= lpric_pkg::ALS_PARAM_RESET;
            ALS_PARAM_OUT <= lpric_pkg::ALS_PARAM_RESET;
            als_timed_d <= 1'b0;
            high_cnt <= 8'h00;
            low_cnt <= 8'h00;
            INT_N_OUT <= 1'b1;
        end else begin
            // [RQ2] [RQ4] results change only from the engines
            if (ALS_VALID_IN) begin
                als_result <= ALS_DATA_IN;
            end
            if (PROX_VALID_IN) begin
                prox_result <= PROX_DATA_IN;
            end
            // [RQ5] control fields, bit 4 held zero
            if (wr_ctrl) begin
                int_ctrl <= shift & lpric_pkg::CTRL_WRITE_MASK;
            end
            // [RQ10] thresholds, upper byte at lower address
            if (wr_low_hi) begin
                thr_low[15:8] <= shift;
            end
            if (wr_low_lo) begin
                thr_low[7:0] <= shift;
            end
            if (wr_high_hi) begin
                thr_high[15:8] <= shift;
            end
            if (wr_high_lo) begin
                thr_high[7:0] <= shift;
            end
            if (sel_valid) begin
                high_cnt <= next_high_cnt;
                low_cnt <= next_low_cnt;
            end
            // [RQ11] sticky cause bits
            status <= next_status;
            // [RQ12] interrupt low while any cause set
            INT_N_OUT <= ~(|next_status);
            // [RQ8] pending parameter taken while off or on restart
            if (wr_param) begin
                als_param_pending <= shift;
            end
            als_timed_d <= ALS_TIMED_ON_IN;
            if (!ALS_TIMED_ON_IN || als_timed_rise) begin
                ALS_PARAM_OUT <= als_param_pending;
            end
        end
    end

endmodule // lpric_ctrl

// file: tb/lpric_props.sv
// lpric_props: port-level checks of the result and interrupt block.
// assumes: bound to lpric_ctrl; serial timing as the host model drives it.
`timescale 1ns/100ps
module lpric_props (
    // clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    // serial port
    input wire logic SCL_IN,
    input wire logic SDA_OE_N_OUT,
    // measurement and outputs
    input wire logic ALS_VALID_IN,
    input wire logic PROX_VALID_IN,
    input wire logic ALS_TIMED_ON_IN,
    input wire logic [7:0] ALS_PARAM_OUT,
    input wire logic INT_N_OUT
);
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);
    sequence s_int_held;
        !INT_N_OUT [*8];
    endsequence
    sequence s_acked;
        ##[0:3] !SDA_OE_N_OUT;
    endsequence
    a_int_fall_cause: assert property ($fell(INT_N_OUT) |->
        $past(ALS_VALID_IN) || $past(PROX_VALID_IN)) else $error("interrupt fell without sample");
    a_int_sticky: assert property ($fell(INT_N_OUT) |=> s_int_held)
        else $error("interrupt did not stay low");
    a_int_clear_ack: assert property ($rose(INT_N_OUT) |-> s_acked)
        else $error("interrupt rose outside a host write");
    a_reset_values: assert property ($rose(NRST_IN) |-> INT_N_OUT && SDA_OE_N_OUT &&
        ALS_PARAM_OUT === lpric_pkg::ALS_PARAM_RESET) else $error("bad values after reset");
    a_param_frozen: assert property ($changed(ALS_PARAM_OUT) |->
        !$past(ALS_TIMED_ON_IN) || !$past(ALS_TIMED_ON_IN, 2)) else $error("parameter changed");
    a_drive_scl_low: assert property ($changed(SDA_OE_N_OUT) |-> !SCL_IN)
        else $error("data drive changed while clock high");
    a_drive_stands: assert property ($fell(SDA_OE_N_OUT) |=> !SDA_OE_N_OUT [*6])
        else $error("data drive too short");
    a_drive_bounded: assert property (!SDA_OE_N_OUT |-> ##[1:200] SDA_OE_N_OUT)
        else $error("data line held too long");
endmodule // lpric_props

bind lpric_ctrl lpric_props lpric_props_i (.CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN),
    .SCL_IN(SCL_IN), .SDA_OE_N_OUT(SDA_OE_N_OUT), .ALS_VALID_IN(ALS_VALID_IN),
    .PROX_VALID_IN(PROX_VALID_IN), .ALS_TIMED_ON_IN(ALS_TIMED_ON_IN),
    .ALS_PARAM_OUT(ALS_PARAM_OUT), .INT_N_OUT(INT_N_OUT));

// file: tb/lpric_host.sv
// lpric_host: two-wire bus master model with register read and write tasks.
// assumes: open-drain wire with pull-up resolved outside; changes at falling edge.
`timescale 1ns/100ps
module lpric_host #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    // clock
    input wire logic clk_in,
    // bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic start;
        sda_out = 1'b1;
        hold(8);
        scl_out = 1'b1;
        hold(8);
        sda_out = 1'b0;
        hold(8);
        scl_out = 1'b0;
        hold(2);
    endtask
    task automatic stop;
        sda_out = 1'b0;
        hold(8);
        scl_out = 1'b1;
        hold(8);
        sda_out = 1'b1;
        hold(8);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_out = b;
        hold(8);
        scl_out = 1'b1;
        hold(4);
        r = sda_in;
        hold(4);
        scl_out = 1'b0;
        hold(2);
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, ack);
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic probe(input logic [6:0] a, output logic ack);
        start;
        put({a, 1'b0}, ack);
        stop;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ack);
        logic k1, k2, k3;
        start;
        put({ADDR, 1'b0}, k1);
        put(a, k2);
        put(d, k3);
        stop;
        ack = k1 | k2 | k3;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        logic k;
        start;
        put({ADDR, 1'b0}, k);
        put(a, k);
        start;
        put({ADDR, 1'b1}, k);
        get(d);
        stop;
    endtask
endmodule // lpric_host

// file: tb/testbench.sv
// testbench: register map, threshold runs and sticky status of lpric_ctrl.
// assumes: lpric_host as bus master; inputs change at the falling edge.
`timescale 1ns/100ps
module testbench;
    logic core_clk = 1'b0, nrst = 1'b0, scl, host_sda, als_valid = 1'b0, prox_valid = 1'b0;
    logic timed = 1'b0, sda_out, sda_oe_n, int_n, ack, sel, up;
    logic [15:0] als_data = 16'h0000, prox_data = 16'h0000, va, vp;
    logic [7:0] als_param, rd, r8;
    wire sda_wire;
    int failures = 0, checks = 0;
    integer seed = 32'h646f372c;
    localparam logic [31:0] THR = 32'h1000_8000;
    always #2.5 core_clk = ~core_clk;
    assign sda_wire = host_sda & (sda_oe_n | sda_out);
    lpric_ctrl lpric_ctrl_i (.CORE_CLK_IN(core_clk), .NRST_IN(nrst), .SCL_IN(scl),
        .SDA_IN(sda_wire), .SDA_OUT(sda_out), .SDA_OE_N_OUT(sda_oe_n),
        .ALS_VALID_IN(als_valid), .ALS_DATA_IN(als_data), .PROX_VALID_IN(prox_valid),
        .PROX_DATA_IN(prox_data), .ALS_TIMED_ON_IN(timed), .ALS_PARAM_OUT(als_param),
        .INT_N_OUT(int_n));
    lpric_host lpric_host_i (.clk_in(core_clk), .sda_in(sda_wire), .scl_out(scl),
        .sda_out(host_sda));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic test_done;
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_bit(input string what, input logic e, input logic s);
        checks++;
        if (s !== e) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, e, s);
        end
    endtask
    task automatic pulse(input logic to_als, input logic [15:0] d);
        @(negedge core_clk);
        if (to_als) begin
            als_data = d;
            als_valid = 1'b1;
        end else begin
            prox_data = d;
            prox_valid = 1'b1;
        end
        @(negedge core_clk);
        als_valid = 1'b0;
        prox_valid = 1'b0;
    endtask
    function automatic logic [7:0] result_byte(input int i);
        return (i < 2) ? va[15 - 8 * i -: 8] : vp[31 - 8 * i -: 8];
    endfunction
    function automatic logic [15:0] outside(input logic above);
        logic [15:0] r;
        r = 16'($random(seed));
        return above ? (r | 16'h8001) : (r & 16'h0fff);
    endfunction
    initial begin
        repeat (100000) @(posedge core_clk);
        failures++;
        test_done;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(negedge core_clk);
        nrst = 1'b1;
        repeat (5) @(negedge core_clk);
        cmp_byte("param", lpric_pkg::ALS_PARAM_RESET, als_param);
        lpric_host_i.rd(lpric_pkg::ADDR_INT_CTRL, rd);
        cmp_byte("ctrl reset", lpric_pkg::INT_CTRL_RESET, rd);
        lpric_host_i.probe(7'h2b, ack);
        cmp_bit("foreign nack", 1'b1, ack);
        lpric_host_i.rd(8'h80, rd);
        cmp_byte("unmapped", 8'h00, rd);
        va = 16'($random(seed));
        vp = 16'($random(seed));
        pulse(1'b1, va);
        pulse(1'b0, vp);
        cmp_bit("int_n", 1'b1, int_n);
        for (int i = 0; i < 4; i++) begin
            lpric_host_i.wr(lpric_pkg::ADDR_ALS_HI + 8'(i), 8'($random(seed)), ack);
            lpric_host_i.rd(lpric_pkg::ADDR_ALS_HI + 8'(i), rd);
            cmp_byte("result", result_byte(i), rd);
        end
        r8 = 8'($random(seed));
        lpric_host_i.wr(lpric_pkg::ADDR_INT_CTRL, r8, ack);
        cmp_bit("ctrl ack", 1'b0, ack);
        cmp_bit("data drive", 1'b0, sda_out);
        lpric_host_i.rd(lpric_pkg::ADDR_INT_CTRL, rd);
        cmp_byte("ctrl", r8 & 8'hef, rd);
        for (int i = 0; i < 4; i++)
            lpric_host_i.wr(lpric_pkg::ADDR_THR_LOW_HI + 8'(i), THR[31 - 8 * i -: 8], ack);
        for (int i = 0; i < 4; i++) begin
            lpric_host_i.rd(lpric_pkg::ADDR_THR_LOW_HI + 8'(i), rd);
            cmp_byte("threshold", THR[31 - 8 * i -: 8], rd);
        end
        // threshold runs for every count code
        for (int n = 0; n < 8; n++) begin
            sel = n[0];
            up = n[1];
            lpric_host_i.wr(lpric_pkg::ADDR_INT_CTRL, {3'(n), 4'h1, sel}, ack);
            pulse(sel, up ? 16'h8000 : 16'h1000);
            for (int k = 1; k < (1 << n); k++) begin
                pulse(sel, outside(up));
                pulse(!sel, outside(up));
            end
            cmp_bit("int_n early", 1'b1, int_n);
            pulse(sel, outside(up));
            cmp_bit("int_n fire", 1'b0, int_n);
            lpric_host_i.rd(lpric_pkg::ADDR_INT_STATUS, rd);
            cmp_byte("status", up ? 8'h01 : 8'h02, rd);
            lpric_host_i.wr(lpric_pkg::ADDR_INT_STATUS, 8'h0f, ack);
            cmp_bit("int_n clear", 1'b1, int_n);
        end
        // ready interrupts and partial clear
        lpric_host_i.wr(lpric_pkg::ADDR_INT_CTRL, 8'h0c, ack);
        pulse(1'b1, outside(1'b0));
        pulse(1'b0, outside(1'b1));
        lpric_host_i.rd(lpric_pkg::ADDR_INT_STATUS, rd);
        cmp_byte("ready status", 8'h0c, rd);
        lpric_host_i.wr(lpric_pkg::ADDR_INT_STATUS, 8'h04, ack);
        lpric_host_i.rd(lpric_pkg::ADDR_INT_STATUS, rd);
        cmp_byte("partial clear", 8'h08, rd);
        cmp_bit("int_n held", 1'b0, int_n);
        lpric_host_i.wr(lpric_pkg::ADDR_INT_STATUS, 8'h08, ack);
        cmp_bit("int_n free", 1'b1, int_n);
        // ambient parameter held while timed mode runs
        timed = 1'b1;
        r8 = 8'($random(seed));
        lpric_host_i.wr(lpric_pkg::ADDR_ALS_PARAM, r8, ack);
        cmp_byte("param held", lpric_pkg::ALS_PARAM_RESET, als_param);
        timed = 1'b0;
        repeat (3) @(negedge core_clk);
        cmp_byte("param taken", r8, als_param);
        test_done;
    end
endmodule // testbench
